// ===== hw/bus_pin_general_io_ports.sv
// general-purpose ports on bus and interrupt pins, behind an Avalon-MM slave
//
// Contract
// R1: spare bus pins usable as general I/O
// R2: two output-only groups share data/assign
// R3: output and bidir accesses take three cycles
// R4: four bidir groups; last has bits 2..7
// R5: five-pin bus-side port, two-cycle access
// R6: seven interrupt pins form one I/O port
// R7: asserted pin requests interrupt at its level
// R8: interrupt-shared port accesses take two cycles
// R9: assign bit selects I/O; dir gates driver
//
// Added by the designer: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "gpio_ports_defines.svh"
module bus_pin_general_io_ports
    import gpio_ports_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic        clk_en_i,
    input  wire logic [5:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    output logic      [7:0]  first_output_group_pins_o,
    output logic      [7:0]  second_output_group_pins_o,
    input  wire logic [31:0] bidir_group_pins_i,
    output logic      [31:0] bidir_group_pins_o,
    output logic      [31:0] bidir_group_pins_oe_o,
    input  wire logic [31:0] bidir_prim_out_i,
    input  wire logic [31:0] bidir_prim_oe_i,
    input  wire logic [4:0]  bus_side_io_pins_i,
    output logic      [4:0]  bus_side_io_pins_o,
    output logic      [4:0]  bus_side_io_pins_oe_o,
    input  wire logic [4:0]  bus_prim_out_i,
    input  wire logic [4:0]  bus_prim_oe_i,
    input  wire logic [6:0]  interrupt_shared_io_pins_i,
    output logic      [6:0]  interrupt_shared_io_pins_o,
    output logic      [6:0]  interrupt_shared_io_pins_oe_o,
    output logic      [6:0]  irq_level_req_o
);
    // -------------------------------------------------------------
    // access timing
    // -------------------------------------------------------------
    access_state_e state_q;
    logic [1:0]    cnt_q;
    logic [1:0]    need_cyc;
    logic          req;
    logic          last;
    logic          wr_go;
    logic          rd_go;

    assign req = avs_read_i || avs_write_i;

    always_comb begin
        case (avs_address_i)
            `OFS_BUS_DATA, `OFS_BUS_DIR, `OFS_BUS_ASSIGN: need_cyc = `FAST_ACCESS_CYC; // R5
            `OFS_IRQ_DATA, `OFS_IRQ_DIR, `OFS_IRQ_ASSIGN,
            `OFS_IRQ_PENDING: need_cyc = `FAST_ACCESS_CYC; // R8
            default: need_cyc = `SLOW_ACCESS_CYC; // R3
        endcase
    end

    // request completes on the cycle the counter reaches its target
    assign last  = (state_q == ACC_WAIT) && (cnt_q == need_cyc - 2'h1);
    assign wr_go = clk_en_i && last && avs_write_i;
    assign rd_go = clk_en_i && last && avs_read_i;
    // held high while frozen, so no completion is seen that does not land
    assign avs_waitrequest_o = !(last && clk_en_i);

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= ACC_IDLE;
            cnt_q   <= 2'h0;
        end else if (clk_en_i) begin
            case (state_q)
                ACC_IDLE: begin
                    if (req) begin
                        state_q <= ACC_WAIT;
                        cnt_q   <= 2'h1;
                    end
                end
                ACC_WAIT: begin
                    if (last) begin
                        state_q <= ACC_DONE;
                    end else begin
                        cnt_q <= cnt_q + 2'h1;
                    end
                end
                ACC_DONE: begin
                    state_q <= ACC_IDLE;
                    cnt_q   <= 2'h0;
                end
                default: begin
                    state_q <= ACC_IDLE;
                    cnt_q   <= 2'h0;
                end
            endcase
        end
    end

    // -------------------------------------------------------------
    // output-only groups
    // -------------------------------------------------------------
    logic [15:0] out_data_q;
    logic [15:0] out_assign_q;
    logic [15:0] out_prim;
    logic [15:0] out_wmask;

    assign out_prim  = 16'h0000;
    assign out_wmask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            out_data_q <= 16'h0000;
        end else if (wr_go && avs_address_i == `OFS_OUT_DATA) begin
            out_data_q <= (out_data_q & ~out_wmask) | (avs_writedata_i[15:0] & out_wmask); // R2
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            out_assign_q <= 16'h0000;
        end else if (wr_go && avs_address_i == `OFS_OUT_ASSIGN) begin
            out_assign_q <= (out_assign_q & ~out_wmask) | (avs_writedata_i[15:0] & out_wmask);
        end
    end

    // primary bus function drives low when not reassigned
    always_comb begin
        first_output_group_pins_o  = out_assign_q[7:0] & out_data_q[7:0]
                                   | ~out_assign_q[7:0] & out_prim[7:0]; // R1 R2
        second_output_group_pins_o = out_assign_q[15:8] & out_data_q[15:8]
                                   | ~out_assign_q[15:8] & out_prim[15:8];
    end

    // -------------------------------------------------------------
    // pin slices: four bidir groups, bus port, interrupt port
    // -------------------------------------------------------------
    logic [31:0] bd_data;
    logic [31:0] bd_dir;
    logic [31:0] bd_asg;
    logic [31:0] bd_lvl;
    logic [31:0] bd_wdata;
    logic [31:0] bd_out_raw;
    logic [31:0] bd_oe_raw;
    logic [31:0] impl_mask;

    assign impl_mask = {`LAST_GROUP_MASK, 24'hff_ffff}; // R4
    assign bd_wdata  = avs_writedata_i & impl_mask;
    assign bidir_group_pins_o    = bd_out_raw & impl_mask;
    assign bidir_group_pins_oe_o = bd_oe_raw & impl_mask;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_bidir
            io_pin_slice #(.WIDTH(8)) u_slice (
                .core_clk_i  (core_clk_i),
                .rst_i       (rst_i),
                .clk_en_i    (clk_en_i),
                .wr_data_i   (wr_go && avs_address_i == `OFS_BIDIR_DATA && avs_byteenable_i[g]),
                .wr_dir_i    (wr_go && avs_address_i == `OFS_BIDIR_DIR && avs_byteenable_i[g]),
                .wr_assign_i (wr_go && avs_address_i == `OFS_BIDIR_ASSIGN
                              && avs_byteenable_i[g]),
                .wdata_i     (bd_wdata[g*8 +: 8]),
                .pin_in_i    (bidir_group_pins_i[g*8 +: 8]),
                .prim_out_i  (bidir_prim_out_i[g*8 +: 8]),
                .prim_oe_i   (bidir_prim_oe_i[g*8 +: 8]),
                .data_o      (bd_data[g*8 +: 8]),
                .dir_o       (bd_dir[g*8 +: 8]),
                .assign_o    (bd_asg[g*8 +: 8]),
                .pin_level_o (bd_lvl[g*8 +: 8]),
                .pin_out_o   (bd_out_raw[g*8 +: 8]),
                .pin_oe_o    (bd_oe_raw[g*8 +: 8])
            ); // R4 R9
        end
    endgenerate

    logic [4:0] bs_data;
    logic [4:0] bs_dir;
    logic [4:0] bs_asg;
    logic [4:0] bs_lvl;

    io_pin_slice #(.WIDTH(5)) u_bus_side (
        .core_clk_i  (core_clk_i),
        .rst_i       (rst_i),
        .clk_en_i    (clk_en_i),
        .wr_data_i   (wr_go && avs_address_i == `OFS_BUS_DATA && avs_byteenable_i[0]),
        .wr_dir_i    (wr_go && avs_address_i == `OFS_BUS_DIR && avs_byteenable_i[0]),
        .wr_assign_i (wr_go && avs_address_i == `OFS_BUS_ASSIGN && avs_byteenable_i[0]),
        .wdata_i     (avs_writedata_i[4:0] & `BUS_PORT_MASK),
        .pin_in_i    (bus_side_io_pins_i),
        .prim_out_i  (bus_prim_out_i),
        .prim_oe_i   (bus_prim_oe_i),
        .data_o      (bs_data),
        .dir_o       (bs_dir),
        .assign_o    (bs_asg),
        .pin_level_o (bs_lvl),
        .pin_out_o   (bus_side_io_pins_o),
        .pin_oe_o    (bus_side_io_pins_oe_o)
    ); // R1 R5

    logic [6:0] iq_data;
    logic [6:0] iq_dir;
    logic [6:0] iq_asg;
    logic [6:0] iq_lvl;

    // interrupt role is input only: no primary driver
    io_pin_slice #(.WIDTH(7)) u_irq_port (
        .core_clk_i  (core_clk_i),
        .rst_i       (rst_i),
        .clk_en_i    (clk_en_i),
        .wr_data_i   (wr_go && avs_address_i == `OFS_IRQ_DATA && avs_byteenable_i[0]),
        .wr_dir_i    (wr_go && avs_address_i == `OFS_IRQ_DIR && avs_byteenable_i[0]),
        .wr_assign_i (wr_go && avs_address_i == `OFS_IRQ_ASSIGN && avs_byteenable_i[0]),
        .wdata_i     (avs_writedata_i[6:0]),
        .pin_in_i    (interrupt_shared_io_pins_i),
        .prim_out_i  (7'h00),
        .prim_oe_i   (7'h00),
        .data_o      (iq_data),
        .dir_o       (iq_dir),
        .assign_o    (iq_asg),
        .pin_level_o (iq_lvl),
        .pin_out_o   (interrupt_shared_io_pins_o),
        .pin_oe_o    (interrupt_shared_io_pins_oe_o)
    ); // R6

    // request at level i while pin i is in interrupt role and asserted
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_level_req_o <= 7'h00;
        end else if (clk_en_i) begin
            irq_level_req_o <= interrupt_shared_io_pins_i & ~iq_asg; // R7
        end
    end

    // -------------------------------------------------------------
    // read data
    // -------------------------------------------------------------
    logic [31:0] rd_mux;

    always_comb begin
        case (avs_address_i)
            `OFS_OUT_DATA:     rd_mux = {16'h0000, out_data_q};
            `OFS_OUT_ASSIGN:   rd_mux = {16'h0000, out_assign_q};
            `OFS_BIDIR_DATA:   rd_mux = bd_lvl & impl_mask;
            `OFS_BIDIR_DIR:    rd_mux = bd_dir & impl_mask;
            `OFS_BIDIR_ASSIGN: rd_mux = bd_asg & impl_mask;
            `OFS_BUS_DATA:     rd_mux = {27'h0, bs_lvl};
            `OFS_BUS_DIR:      rd_mux = {27'h0, bs_dir};
            `OFS_BUS_ASSIGN:   rd_mux = {27'h0, bs_asg};
            `OFS_IRQ_DATA:     rd_mux = {25'h0, iq_lvl};
            `OFS_IRQ_DIR:      rd_mux = {25'h0, iq_dir};
            `OFS_IRQ_ASSIGN:   rd_mux = {25'h0, iq_asg};
            `OFS_IRQ_PENDING:  rd_mux = {25'h0, irq_level_req_o};
            default:           rd_mux = `UNMAPPED_DATA;
        endcase
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (clk_en_i && req && state_q == ACC_IDLE) begin
            avs_readdata_o <= rd_mux;
        end
    end

    logic unused_ok;
    assign unused_ok = &{bs_data, iq_data, rd_go};
endmodule

// ===== hw/gpio_ports_defines.svh
// register map, field constants and access timing for the general-purpose ports
`ifndef GPIO_PORTS_DEFINES_SVH
`define GPIO_PORTS_DEFINES_SVH

// byte offsets of the register words
`define OFS_OUT_DATA     6'h00
`define OFS_OUT_ASSIGN   6'h04
`define OFS_BIDIR_DATA   6'h08
`define OFS_BIDIR_DIR    6'h0c
`define OFS_BIDIR_ASSIGN 6'h10
`define OFS_BUS_DATA     6'h14
`define OFS_BUS_DIR      6'h18
`define OFS_BUS_ASSIGN   6'h1c
`define OFS_IRQ_DATA     6'h20
`define OFS_IRQ_DIR      6'h24
`define OFS_IRQ_ASSIGN   6'h28
`define OFS_IRQ_PENDING  6'h2c

// access lengths in clock cycles
`define SLOW_ACCESS_CYC  2'h3
`define FAST_ACCESS_CYC  2'h2

// implemented bits of the last bidirectional group
`define LAST_GROUP_MASK  8'hfc
// implemented bits of the bus-side port
`define BUS_PORT_MASK    5'h1f
`define UNMAPPED_DATA    32'h0000_0000

`endif

// ===== hw/gpio_ports_pkg.sv
// types shared by the general-purpose port block
package gpio_ports_pkg;
    typedef enum logic [2:0] {
        ACC_IDLE = 3'b001,
        ACC_WAIT = 3'b010,
        ACC_DONE = 3'b100
    } access_state_e;
endpackage

// ===== hw/io_pin_slice.sv
// one group of general-purpose pins: data, direction and pin assignment
`timescale 1ns/100ps
module io_pin_slice #(
    parameter int WIDTH = 8
) (
    input  wire logic             core_clk_i,
    input  wire logic             rst_i,
    input  wire logic             clk_en_i,
    input  wire logic             wr_data_i,
    input  wire logic             wr_dir_i,
    input  wire logic             wr_assign_i,
    input  wire logic [WIDTH-1:0] wdata_i,
    input  wire logic [WIDTH-1:0] pin_in_i,
    input  wire logic [WIDTH-1:0] prim_out_i,
    input  wire logic [WIDTH-1:0] prim_oe_i,
    output logic      [WIDTH-1:0] data_o,
    output logic      [WIDTH-1:0] dir_o,
    output logic      [WIDTH-1:0] assign_o,
    output logic      [WIDTH-1:0] pin_level_o,
    output logic      [WIDTH-1:0] pin_out_o,
    output logic      [WIDTH-1:0] pin_oe_o
);
    logic [WIDTH-1:0] data_q;
    logic [WIDTH-1:0] dir_q;
    logic [WIDTH-1:0] assign_q;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            data_q <= '0;
        end else if (clk_en_i && wr_data_i) begin
            data_q <= wdata_i;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dir_q <= '0;
        end else if (clk_en_i && wr_dir_i) begin
            dir_q <= wdata_i;
        end
    end

    // assign bit high selects general-purpose use
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            assign_q <= '0;
        end else if (clk_en_i && wr_assign_i) begin
            assign_q <= wdata_i;
        end
    end

    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            pin_out_o[i]   = assign_q[i] ? data_q[i] : prim_out_i[i];
            pin_oe_o[i]    = assign_q[i] ? dir_q[i] : prim_oe_i[i];
            pin_level_o[i] = (assign_q[i] && dir_q[i]) ? data_q[i] : pin_in_i[i];
        end
    end

    assign data_o   = data_q;
    assign dir_o    = dir_q;
    assign assign_o = assign_q;
endmodule

// ===== tb/board_pins.sv
// board side of the general-purpose pins: resolves each line from both drivers
`timescale 1ns/100ps
module board_pins (
    input  wire logic [31:0] bidir_out_i,
    input  wire logic [31:0] bidir_oe_i,
    input  wire logic [31:0] bidir_drv_i,
    output logic      [31:0] bidir_pin_o,
    input  wire logic [4:0]  bus_out_i,
    input  wire logic [4:0]  bus_oe_i,
    input  wire logic [4:0]  bus_drv_i,
    output logic      [4:0]  bus_pin_o,
    input  wire logic [6:0]  irq_out_i,
    input  wire logic [6:0]  irq_oe_i,
    input  wire logic [6:0]  irq_drv_i,
    output logic      [6:0]  irq_pin_o
);
    // device driver wins where enabled, board source elsewhere
    assign bidir_pin_o = (bidir_oe_i & bidir_out_i) | (~bidir_oe_i & bidir_drv_i);
    assign bus_pin_o   = (bus_oe_i & bus_out_i) | (~bus_oe_i & bus_drv_i);
    assign irq_pin_o   = (irq_oe_i & irq_out_i) | (~irq_oe_i & irq_drv_i);
endmodule

// ===== tb/bus_pin_general_io_ports_tb.sv
// register-level test of the general-purpose port block
`timescale 1ns/100ps
`include "gpio_ports_defines.svh"
module bus_pin_general_io_ports_tb;
    logic core_clk_i = 0, rst_i = 1, clk_en_i = 1, avs_read_i = 0, avs_write_i = 0;
    logic [5:0] avs_address_i = 6'h0;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rdq;
    logic [3:0] avs_byteenable_i = 4'hf;
    logic avs_waitrequest_o;
    logic [7:0] first_o, second_o;
    logic [31:0] bd_i, bd_o, bd_oe, bd_drv = 32'h0;
    logic [31:0] bd_po = 32'hffffffff, bd_poe = 32'h0f0f0f0f;
    logic [4:0] bs_i, bs_o, bs_oe, bs_drv = 5'h0, bs_po = 5'h1f, bs_poe = 5'h0a;
    logic [6:0] iq_i, iq_o, iq_oe, iq_drv = 7'h0, irq_level_req_o;
    int err_total = 0, comparisons = 0;
    always #2.5 core_clk_i = ~core_clk_i;
    bus_pin_general_io_ports DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .first_output_group_pins_o(first_o), .second_output_group_pins_o(second_o),
        .bidir_group_pins_i(bd_i), .bidir_group_pins_o(bd_o), .bidir_group_pins_oe_o(bd_oe),
        .bidir_prim_out_i(bd_po), .bidir_prim_oe_i(bd_poe), .bus_side_io_pins_i(bs_i),
        .bus_side_io_pins_o(bs_o), .bus_side_io_pins_oe_o(bs_oe), .bus_prim_out_i(bs_po),
        .bus_prim_oe_i(bs_poe), .interrupt_shared_io_pins_i(iq_i),
        .interrupt_shared_io_pins_o(iq_o), .interrupt_shared_io_pins_oe_o(iq_oe),
        .irq_level_req_o(irq_level_req_o));
    board_pins board (.bidir_out_i(bd_o), .bidir_oe_i(bd_oe), .bidir_drv_i(bd_drv),
        .bidir_pin_o(bd_i), .bus_out_i(bs_o), .bus_oe_i(bs_oe), .bus_drv_i(bs_drv),
        .bus_pin_o(bs_i), .irq_out_i(iq_o), .irq_oe_i(iq_oe), .irq_drv_i(iq_drv),
        .irq_pin_o(iq_i));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic end_sim();
        $display("compares %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic wr, input logic [5:0] a, input logic [31:0] d,
                       input logic [3:0] b);
        int n;
        n = 0;
        @(posedge core_clk_i);
        avs_address_i <= a;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        avs_writedata_i <= d;
        avs_byteenable_i <= b;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 20);
        if (avs_waitrequest_o !== 1'b0) begin
            err_total++;
            end_sim();
        end else begin
            rdq = avs_readdata_o;
            avs_read_i <= 1'b0;
            avs_write_i <= 1'b0;
            chk(n, (a >= 6'h14 && a <= 6'h2c) ? 2 : 3);
            // let a landed write settle before callers look at pins
            @(posedge core_clk_i);
        end
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge core_clk_i);
        rst_i <= 1'b0;
        @(posedge core_clk_i);
        #1;
        chk(avs_waitrequest_o, 1'b1);
        chk({second_o, first_o}, 16'h0);
        chk(bd_o, 32'hfcffffff);
        chk(bd_oe, 32'h0c0f0f0f);
        chk(bs_oe, 5'h0a);
        $display("test reset done");
        for (int i = 0; i <= 12; i++) begin
            acc(1'b0, 6'(i * 4), 32'h0, 4'hf);
            chk(rdq, (i == 2) ? 32'h0c0f0f0f : ((i == 5) ? 32'h0000000a : 32'h0));
        end
        $display("test timing done");
        acc(1'b1, `OFS_OUT_DATA, 32'h0000a55a, 4'hf);
        acc(1'b1, `OFS_OUT_ASSIGN, 32'h0000ffff, 4'hf);
        chk({second_o, first_o}, 16'ha55a);
        acc(1'b1, `OFS_OUT_ASSIGN, 32'h0, 4'h1);
        chk({second_o, first_o}, 16'ha500);
        acc(1'b1, 6'h30, 32'hffffffff, 4'hf);
        chk({second_o, first_o}, 16'ha500);
        acc(1'b1, `OFS_OUT_ASSIGN, 32'h0, 4'hf);
        $display("test output groups done");
        acc(1'b1, `OFS_BIDIR_ASSIGN, 32'hffffffff, 4'hf);
        acc(1'b1, `OFS_BIDIR_DIR, 32'hffffffff, 4'hf);
        acc(1'b1, `OFS_BIDIR_DATA, 32'h12345678, 4'hf);
        chk(bd_o, 32'h10345678);
        chk(bd_oe, 32'hfcffffff);
        acc(1'b0, `OFS_BIDIR_ASSIGN, 32'h0, 4'hf);
        chk(rdq, 32'hfcffffff);
        bd_drv <= 32'ha5a5a5a5;
        acc(1'b1, `OFS_BIDIR_DIR, 32'h0, 4'hf);
        chk(bd_oe, 32'h0);
        acc(1'b0, `OFS_BIDIR_DATA, 32'h0, 4'hf);
        chk(rdq, 32'ha4a5a5a5);
        $display("test bidir groups done");
        acc(1'b1, `OFS_BUS_ASSIGN, 32'h1f, 4'hf);
        acc(1'b1, `OFS_BUS_DIR, 32'h1f, 4'hf);
        acc(1'b1, `OFS_BUS_DATA, 32'h15, 4'hf);
        chk({bs_oe, bs_o}, 10'h3f5);
        bs_drv <= 5'h0a;
        acc(1'b1, `OFS_BUS_DIR, 32'h0, 4'hf);
        acc(1'b0, `OFS_BUS_DATA, 32'h0, 4'hf);
        chk(rdq, 32'h0a);
        $display("test bus port done");
        clk_en_i <= 1'b0;
        iq_drv <= 7'h29;
        repeat (3) @(posedge core_clk_i);
        chk(irq_level_req_o, 7'h00);
        clk_en_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        chk(irq_level_req_o, 7'h29);
        acc(1'b0, `OFS_IRQ_PENDING, 32'h0, 4'hf);
        chk(rdq, 32'h29);
        acc(1'b1, `OFS_IRQ_ASSIGN, 32'h7f, 4'hf);
        acc(1'b1, `OFS_IRQ_DIR, 32'h7f, 4'hf);
        acc(1'b1, `OFS_IRQ_DATA, 32'h55, 4'hf);
        repeat (2) @(posedge core_clk_i);
        #1;
        chk({iq_oe, iq_o, irq_level_req_o}, 21'h1fea80);
        $display("test interrupt port done");
        end_sim();
    end
endmodule
bind bus_pin_general_io_ports gpio_ports_monitor mon (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .clk_en_i(clk_en_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .first_output_group_pins_o(first_output_group_pins_o),
    .second_output_group_pins_o(second_output_group_pins_o),
    .bidir_group_pins_o(bidir_group_pins_o), .bidir_group_pins_oe_o(bidir_group_pins_oe_o),
    .interrupt_shared_io_pins_i(interrupt_shared_io_pins_i),
    .interrupt_shared_io_pins_oe_o(interrupt_shared_io_pins_oe_o),
    .irq_level_req_o(irq_level_req_o));

// ===== tb/gpio_ports_monitor.sv
// port-level checks for the general-purpose port block
`timescale 1ns/100ps
module gpio_ports_monitor (
    input wire logic        core_clk_i,
    input wire logic        rst_i,
    input wire logic        clk_en_i,
    input wire logic [5:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0]  avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic [7:0]  first_output_group_pins_o,
    input wire logic [7:0]  second_output_group_pins_o,
    input wire logic [31:0] bidir_group_pins_o,
    input wire logic [31:0] bidir_group_pins_oe_o,
    input wire logic [6:0]  interrupt_shared_io_pins_i,
    input wire logic [6:0]  interrupt_shared_io_pins_oe_o,
    input wire logic [6:0]  irq_level_req_o
);
    logic req;
    logic fast;
    logic done;
    assign req  = avs_read_i || avs_write_i;
    assign fast = avs_address_i >= 6'h14 && avs_address_i <= 6'h2c && avs_address_i[1:0] == 2'h0;
    assign done = req && !avs_waitrequest_o;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i || !clk_en_i);
    // ----------------------------------------
    // access timing
    // ----------------------------------------
    sequence req_start;
        req && !$past(req);
    endsequence
    sequence slow_tail;
        avs_waitrequest_o ##1 avs_waitrequest_o ##1 !avs_waitrequest_o;
    endsequence
    sequence fast_tail;
        avs_waitrequest_o ##1 !avs_waitrequest_o;
    endsequence
    slow_access_a: assert property ((req_start ##0 !fast) |-> slow_tail)
        else $error("slow access length wrong");
    fast_access_a: assert property ((req_start ##0 fast) |-> fast_tail)
        else $error("fast access length wrong");
    wait_pulse_a: assert property (done |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    idle_wait_a: assert property (!req |-> avs_waitrequest_o)
        else $error("waitrequest low while idle");
    // ----------------------------------------
    // pins and data
    // ----------------------------------------
    out_clear_a: assert property (done && avs_write_i && avs_address_i == 6'h04 &&
        avs_byteenable_i[1:0] == 2'h3 && avs_writedata_i[15:0] == 16'h0 |->
        ##2 first_output_group_pins_o == 8'h0 && second_output_group_pins_o == 8'h0)
        else $error("output pins driven with assignment cleared");
    unmapped_read_a: assert property (done && avs_read_i && avs_address_i > 6'h2c |->
        avs_readdata_o == 32'h0)
        else $error("unmapped read not zero");
    last_bits_a: assert property (bidir_group_pins_oe_o[25:24] == 2'h0 &&
        bidir_group_pins_o[25:24] == 2'h0)
        else $error("unimplemented bidir bits driven");
    irq_level_a: assert property ((irq_level_req_o & (~$past(interrupt_shared_io_pins_i) |
        $past(interrupt_shared_io_pins_oe_o))) == 7'h0)
        else $error("interrupt level without cause");
endmodule
